/* hdl/pse_events_pkg.sv */
package pse_events_pkg;

  localparam int NUM_CH = 4;
  localparam int NUM_PORT = 2;

  // Command codes of the supply_fault_events_clear byte.
  localparam logic [7:0] CMD_EVENTS_VIEW = 8'h0A;
  localparam logic [7:0] CMD_EVENTS_CLEAR = 8'h0B;

  // Bit positions inside the supply_fault_events_clear byte.
  localparam int EV_THERMAL = 7;
  localparam int EV_LOGIC_LOCKOUT = 6;
  localparam int EV_LOGIC_WARNING = 5;
  localparam int EV_MAIN_UNDERVOLT = 4;
  localparam int EV_OVERLOAD_CH34 = 3;
  localparam int EV_OVERLOAD_CH12 = 2;
  localparam int EV_FAST_SHUTDOWN = 1;
  localparam int EV_MEM_FAULT = 0;

  // Value after power-on reset, and bits kept across a pin reset.
  localparam logic [7:0] EV_POR_VALUE = 8'h70;
  localparam logic [7:0] EV_PRESERVE_MASK = 8'hF0;

  // Lowest assigned class that starts both channels in parallel.
  localparam logic [3:0] CLASS_PARALLEL_MIN = 4'h7;

  // Cool-down after a start fault.
  localparam int CLK_MHZ = 100;
  localparam int COOL_TIME_MS = 1000;
  localparam int COOL_W = 27;
  localparam logic [COOL_W-1:0] COOL_CYCLES_DEF =
    COOL_W'(COOL_TIME_MS * 1000 * CLK_MHZ);

  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_INRUSH = 3'b001,
    CH_HOLD = 3'b010,
    CH_ON = 3'b011,
    CH_COOL = 3'b100
  } ch_state_t;

  typedef struct packed {
    logic thermal_shutdown;
    logic logic_supply_lockout;
    logic logic_supply_warning;
    logic main_supply_undervolt;
    logic [1:0] power_cut_fault;
    logic fast_shutdown_event;
    logic program_memory_fault;
  } supply_evt_t;

  typedef struct packed {
    logic start_req;
    logic inrush_done;
    logic start_fault;
    logic off_req;
  } chan_in_t;

endpackage

/* hdl/pse_inrush_fault_supply_events.sv */
// Operation
// - Single-signature class 6 or lower: one channel does inrush, partner idles.
// - Single-channel inrush ends clean: partner switches on, power-good flags set.
// - Single-channel start fault: both off, 1 s cool-down, both start-fault flags.
// - Single-signature class 7 or 8: both channels do inrush together.
// - Parallel inrush ends clean: power-good flags set, port stays powered.
// - Parallel start fault on either: both off, 1 s cool-down, both flags.
// - Dual-signature: each channel runs inrush alone; faults stay local.
// - Event byte read by two codes; the clear code clears after returning.
// - Clear-on-read releases the active-low interrupt this register holds.
// - Any set event bit drives the summary indication; bits active high.
// - Thermal shutdown sets bit 7 and turns every channel off.
// - Below the low temperature channels may power again, flag regardless.
// - Thermal flag is 0 after power-on, kept across pin reset.
// - Bit 6 latches logic supply lockout; 1 at power-on, kept on pin reset.
// - Bit 5 latches logic supply warning; 1 at power-on, kept on pin reset.
// - Bit 4 latches main supply undervoltage; 1 at power-on, kept on pin.
// - Bit 3 latches summed overload on channels 3 and 4; 0 after resets.
// - Bit 2 latches summed overload on channels 1 and 2; 0 after resets.
// - Bit 1 set when fast shutdown or priority code disables channels.
// - Bit 0 latches program memory fault; 0 after both resets.
// - Preserved bits are not cleared by the external reset pin.
`timescale 1ns/1ps
`default_nettype none
module pse_inrush_fault_supply_events
  import pse_events_pkg::*;
#(
  parameter logic [COOL_W-1:0] COOL_CYCLES = COOL_CYCLES_DEF
)
(
  // Clock, resets and enable.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic ce_in,
  // Register command port.
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Supply, thermal and fault events.
  input wire supply_evt_t supply_evt_in,
  input wire logic temp_below_low_in,
  // Channel control, two 4-pair ports.
  input wire chan_in_t [NUM_CH-1:0] chan_in,
  input wire logic [NUM_PORT-1:0] dual_sig_in,
  input wire logic [NUM_PORT-1:0][3:0] class_in,
  // Channel status.
  output logic [NUM_CH-1:0] chan_on_out,
  output logic [NUM_CH-1:0] inrush_active_out,
  output logic [NUM_CH-1:0] cooldown_out,
  output logic [NUM_CH-1:0] power_good_flag_out,
  output logic [NUM_CH-1:0] start_fault_flag_out,
  // Interrupt.
  output logic supply_event_summary_out,
  output logic int_n_out
);

  function automatic logic class_parallel(input logic [3:0] cls);
    class_parallel = (cls >= CLASS_PARALLEL_MIN);
  endfunction

  function automatic logic is_event_cmd(input logic [7:0] code);
    is_event_cmd = (code == CMD_EVENTS_VIEW) || (code == CMD_EVENTS_CLEAR);
  endfunction

  logic rst_any;
  logic start_ok;
  logic tsd_hold_ff;
  logic [7:0] ev_ff;
  logic [7:0] nxt_ev;
  logic [7:0] set_vec;
  logic cor;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  logic summary_ff;
  logic int_n_ff;
  ch_state_t st_ff [NUM_CH];
  ch_state_t nxt_st [NUM_CH];
  logic [COOL_W-1:0] cnt_ff [NUM_CH];
  logic [NUM_CH-1:0] on_ff;
  logic [NUM_CH-1:0] inrush_ff;
  logic [NUM_CH-1:0] cool_ff;
  logic [NUM_CH-1:0] pg_ff;
  logic [NUM_CH-1:0] strt_ff;
  logic [NUM_PORT-1:0] port_start;
  logic [NUM_PORT-1:0] port_end;
  logic [NUM_PORT-1:0] port_fault;
  logic [NUM_PORT-1:0] port_off;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_any);

  sequence seq_single_go(int p);
    ce_in && port_start[p] && !class_parallel(class_in[p]);
  endsequence

  sequence seq_parallel_go(int p);
    ce_in && port_start[p] && class_parallel(class_in[p]);
  endsequence

  sequence seq_end(int p, logic flt);
    ce_in && port_end[p] && port_fault[p] == flt &&
      !supply_evt_in.thermal_shutdown;
  endsequence

  assign rst_any = rst_in | por_in;
  // Starts are blocked from a thermal trip until the die has cooled.
  assign start_ok = !tsd_hold_ff && !supply_evt_in.thermal_shutdown;

  always_ff @(posedge clk_in)
  begin
    if (por_in)
      tsd_hold_ff <= 1'b0;
    else if (ce_in)
    begin
      if (supply_evt_in.thermal_shutdown)
        tsd_hold_ff <= 1'b1;
      else if (temp_below_low_in)
        tsd_hold_ff <= 1'b0;
    end
  end

  // Event sources, all active high and sticky.
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[EV_THERMAL] = supply_evt_in.thermal_shutdown;
    set_vec[EV_LOGIC_LOCKOUT] = supply_evt_in.logic_supply_lockout;
    set_vec[EV_LOGIC_WARNING] = supply_evt_in.logic_supply_warning;
    set_vec[EV_MAIN_UNDERVOLT] = supply_evt_in.main_supply_undervolt;
    set_vec[EV_OVERLOAD_CH34] = supply_evt_in.power_cut_fault[1];
    set_vec[EV_OVERLOAD_CH12] = supply_evt_in.power_cut_fault[0];
    set_vec[EV_FAST_SHUTDOWN] = supply_evt_in.fast_shutdown_event;
    set_vec[EV_MEM_FAULT] = supply_evt_in.program_memory_fault;
  end

  assign cor = cmd_valid_in && (cmd_code_in == CMD_EVENTS_CLEAR);

  always_comb
  begin
    if (cor)
      nxt_ev = set_vec;
    else
      nxt_ev = ev_ff | set_vec;
  end

  always_ff @(posedge clk_in)
  begin
    if (por_in)
      ev_ff <= EV_POR_VALUE;
    else if (rst_in)
      ev_ff <= ev_ff & EV_PRESERVE_MASK;
    else if (ce_in)
      ev_ff <= nxt_ev;
  end

  // Both codes return the byte as it stood before any clear.
  always_ff @(posedge clk_in)
  begin
    if (rst_any)
    begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      rd_valid_ff <= cmd_valid_in && is_event_cmd(cmd_code_in);
      if (cmd_valid_in && is_event_cmd(cmd_code_in))
        rd_data_ff <= ev_ff;
    end
  end

  // Summary and interrupt follow the byte's next value.
  always_ff @(posedge clk_in)
  begin
    if (por_in)
    begin
      summary_ff <= 1'b1;
      int_n_ff <= 1'b0;
    end
    else if (rst_in)
    begin
      summary_ff <= |(ev_ff & EV_PRESERVE_MASK);
      int_n_ff <= ~|(ev_ff & EV_PRESERVE_MASK);
    end
    else if (ce_in)
    begin
      summary_ff <= |nxt_ev;
      int_n_ff <= ~|nxt_ev;
    end
  end

  // Port-level coupling for single-signature loads.
  for (genvar p = 0; p < NUM_PORT; p++)
  begin : g_port
    localparam int A = 2 * p;
    localparam int B = 2 * p + 1;
    logic par;
    assign par = class_parallel(class_in[p]);
    assign port_start[p] = !dual_sig_in[p] && chan_in[A].start_req &&
      start_ok && st_ff[A] == CH_IDLE && st_ff[B] == CH_IDLE;
    assign port_end[p] = !dual_sig_in[p] && (par ?
      (st_ff[A] == CH_INRUSH && st_ff[B] == CH_INRUSH &&
       chan_in[A].inrush_done && chan_in[B].inrush_done) :
      (st_ff[A] == CH_INRUSH && chan_in[A].inrush_done));
    assign port_fault[p] = chan_in[A].start_fault ||
      (par && chan_in[B].start_fault);
    assign port_off[p] = !dual_sig_in[p] && st_ff[A] == CH_ON &&
      (chan_in[A].off_req || chan_in[B].off_req);

    a_single_start: assert property (seq_single_go(p) |=>
      st_ff[A] == CH_INRUSH && st_ff[B] == CH_HOLD)
      else $error("single inrush start did not idle the partner");
    a_parallel_start: assert property (seq_parallel_go(p) |=>
      st_ff[A] == CH_INRUSH && st_ff[B] == CH_INRUSH)
      else $error("parallel inrush did not start both channels");
    a_end_fault_cool: assert property (seq_end(p, 1'b1) |=>
      st_ff[A] == CH_COOL && st_ff[B] == CH_COOL &&
      start_fault_flag_out[A] && start_fault_flag_out[B] &&
      !chan_on_out[A] && !chan_on_out[B])
      else $error("start fault did not cool both channels");
    a_end_clean_on: assert property (seq_end(p, 1'b0) |=>
      chan_on_out[A] && chan_on_out[B] &&
      power_good_flag_out[A] && power_good_flag_out[B])
      else $error("clean inrush end did not power the port");
  end

  // Per-channel state machines.
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam int P = c / 2;
    localparam int PEER = c ^ 1;
    localparam bit PRIMARY = (c % 2) == 0;

    always_comb
    begin
      nxt_st[c] = st_ff[c];
      case (st_ff[c])
        CH_IDLE:
        begin
          if (dual_sig_in[P])
          begin
            if (chan_in[c].start_req && start_ok)
              nxt_st[c] = CH_INRUSH;
          end
          else if (port_start[P])
          begin
            if (PRIMARY || class_parallel(class_in[P]))
              nxt_st[c] = CH_INRUSH;
            else
              nxt_st[c] = CH_HOLD;
          end
        end
        CH_HOLD:
        begin
          if (port_end[P])
            nxt_st[c] = port_fault[P] ? CH_COOL : CH_ON;
        end
        CH_INRUSH:
        begin
          if (dual_sig_in[P])
          begin
            if (chan_in[c].inrush_done)
              nxt_st[c] = chan_in[c].start_fault ? CH_COOL : CH_ON;
          end
          else if (port_end[P])
            nxt_st[c] = port_fault[P] ? CH_COOL : CH_ON;
        end
        CH_ON:
        begin
          if (dual_sig_in[P] ? chan_in[c].off_req : port_off[P])
            nxt_st[c] = CH_IDLE;
        end
        CH_COOL:
        begin
          if (cnt_ff[c] == '0)
            nxt_st[c] = CH_IDLE;
        end
        default:
          nxt_st[c] = CH_IDLE;
      endcase
      if (supply_evt_in.thermal_shutdown)
        nxt_st[c] = CH_IDLE;
    end

    always_ff @(posedge clk_in)
    begin
      if (rst_any)
        st_ff[c] <= CH_IDLE;
      else if (ce_in)
        st_ff[c] <= nxt_st[c];
    end

    always_ff @(posedge clk_in)
    begin
      if (rst_any)
        cnt_ff[c] <= '0;
      else if (ce_in)
      begin
        if (nxt_st[c] == CH_COOL && st_ff[c] != CH_COOL)
          cnt_ff[c] <= COOL_CYCLES - COOL_W'(1);
        else if (st_ff[c] == CH_COOL && cnt_ff[c] != '0)
          cnt_ff[c] <= cnt_ff[c] - COOL_W'(1);
      end
    end

    always_ff @(posedge clk_in)
    begin
      if (rst_any)
      begin
        on_ff[c] <= 1'b0;
        inrush_ff[c] <= 1'b0;
        cool_ff[c] <= 1'b0;
        pg_ff[c] <= 1'b0;
        strt_ff[c] <= 1'b0;
      end
      else if (ce_in)
      begin
        on_ff[c] <= nxt_st[c] == CH_ON || nxt_st[c] == CH_INRUSH;
        inrush_ff[c] <= nxt_st[c] == CH_INRUSH;
        cool_ff[c] <= nxt_st[c] == CH_COOL;
        pg_ff[c] <= nxt_st[c] == CH_ON;
        if (st_ff[c] == CH_IDLE && nxt_st[c] != CH_IDLE)
          strt_ff[c] <= 1'b0;
        else if (st_ff[c] != CH_COOL && nxt_st[c] == CH_COOL)
          strt_ff[c] <= 1'b1;
      end
    end

    a_dual_isolated: assert property (dual_sig_in[P] && ce_in &&
      st_ff[PEER] == CH_ON && !chan_in[PEER].off_req &&
      !supply_evt_in.thermal_shutdown && st_ff[c] == CH_INRUSH &&
      chan_in[c].inrush_done && chan_in[c].start_fault
      |=> st_ff[c] == CH_COOL && st_ff[PEER] == CH_ON)
      else $error("dual-signature fault disturbed the other channel");
    a_cool_load: assert property ($rose(cool_ff[c]) |->
      cnt_ff[c] == COOL_CYCLES - COOL_W'(1))
      else $error("cool-down did not load its full length");
  end

  assign rd_data_out = rd_data_ff;
  assign rd_valid_out = rd_valid_ff;
  assign chan_on_out = on_ff;
  assign inrush_active_out = inrush_ff;
  assign cooldown_out = cool_ff;
  assign power_good_flag_out = pg_ff;
  assign start_fault_flag_out = strt_ff;
  assign supply_event_summary_out = summary_ff;
  assign int_n_out = int_n_ff;

  a_cor_clears: assert property (ce_in && cor && set_vec == 8'h00
    |=> ev_ff == 8'h00 ##0 int_n_out)
    else $error("clear-on-read left event bits set");
  a_view_keeps: assert property (ce_in && cmd_valid_in &&
    cmd_code_in == CMD_EVENTS_VIEW
    |=> ev_ff == ($past(ev_ff) | $past(set_vec)))
    else $error("plain read changed the event byte");
  a_read_data: assert property (ce_in && cmd_valid_in &&
    is_event_cmd(cmd_code_in)
    |=> rd_valid_out && rd_data_out == $past(ev_ff))
    else $error("event read returned wrong data");
  a_summary_tracks: assert property (ce_in |=>
    supply_event_summary_out == (ev_ff != 8'h00) &&
    int_n_out == (ev_ff == 8'h00))
    else $error("summary does not follow the event byte");
  a_set_wins: assert property (ce_in && cor |=>
    (ev_ff & $past(set_vec)) == $past(set_vec))
    else $error("event lost under clear-on-read");
  a_thermal_off: assert property (ce_in &&
    supply_evt_in.thermal_shutdown
    |=> chan_on_out == '0 && ev_ff[EV_THERMAL])
    else $error("thermal shutdown left a channel on");
  a_cooled_release: assert property (ce_in && temp_below_low_in &&
    !supply_evt_in.thermal_shutdown |=> !tsd_hold_ff)
    else $error("cooled die still blocks channel start");
  a_pin_keeps: assert property (@(posedge clk_in) disable iff (por_in)
    rst_in |=> ev_ff[7:4] == $past(ev_ff[7:4]) &&
      ev_ff[3:0] == 4'h0)
    else $error("pin reset disturbed the event byte");
  a_por_value: assert property (@(posedge clk_in) disable iff (1'b0)
    por_in |=> ev_ff == EV_POR_VALUE)
    else $error("power-on value of the event byte is wrong");

endmodule
`default_nettype wire

/* tb/pse_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pse_host_model
(
  // Clock.
  input wire logic clk_in,
  // Answer from the device.
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in,
  // Command strobe and code.
  output logic cmd_valid_out,
  output logic [7:0] cmd_code_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_code_out = 8'h00;
  end

  // One command, held over its taking edge, answer taken 1 ns after that same edge.
  task automatic access(input logic [7:0] code, output logic [7:0] data,
                        output logic ok);
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_code_out = code;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    cmd_code_out = ~code;
    ok = (rd_valid_in === 1'b1);
    data = rd_data_in;
  endtask
endmodule
`default_nettype wire

/* tb/pse_inrush_fault_supply_events_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pse_inrush_fault_supply_events_tb;
  import pse_events_pkg::*;
  localparam int COOL_N = 20;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic por_in = 1'b1;
  logic temp_low = 1'b1;
  logic ce = 1'b1;
  supply_evt_t evt = '0;
  chan_in_t [NUM_CH-1:0] ch = '0;
  logic [NUM_PORT-1:0] dual = '0;
  logic [NUM_PORT-1:0][3:0] cls = '0;
  logic [7:0] rd_data, cmd_code, d, model, b;
  logic rd_valid, cmd_valid, ok, summ, int_n;
  logic [NUM_CH-1:0] on, inr, cool, pg, sf;
  int mismatches = 0;
  int check_count = 0;
  int i;

  always #5 clk_in = ~clk_in;

  pse_inrush_fault_supply_events #(.COOL_CYCLES(COOL_W'(COOL_N)))
    u_pse_inrush_fault_supply_events (
    .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .ce_in(ce),
    .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .supply_evt_in(evt), .temp_below_low_in(temp_low), .chan_in(ch),
    .dual_sig_in(dual), .class_in(cls), .chan_on_out(on),
    .inrush_active_out(inr), .cooldown_out(cool),
    .power_good_flag_out(pg), .start_fault_flag_out(sf),
    .supply_event_summary_out(summ), .int_n_out(int_n));

  pse_host_model u_pse_host_model (
    .clk_in(clk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
    .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code));

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic rd(input logic [7:0] code);
    u_pse_host_model.access(code, d, ok);
    chk("rd_valid", 8'h01, {7'h00, ok});
    chk("int_n", {7'h00, d == 8'h00 || code == CMD_EVENTS_CLEAR},
        {7'h00, int_n});
  endtask

  task automatic pulse(input logic [7:0] v);
    evt = supply_evt_t'(v);
    cyc(1);
    evt = '0;
  endtask

  task automatic start(input int p, input logic [3:0] c, input logic dl,
                       input logic [1:0] rq);
    cls[p] = c;
    dual[p] = dl;
    cyc(1);
    ch[2*p].start_req = rq[0];
    ch[2*p+1].start_req = rq[1];
    cyc(1);
    ch = '0;
  endtask

  task automatic fin(input int p, input logic [1:0] dn, input logic [1:0] fl);
    ch[2*p].inrush_done = dn[0];
    ch[2*p+1].inrush_done = dn[1];
    ch[2*p].start_fault = fl[0];
    ch[2*p+1].start_fault = fl[1];
    cyc(1);
    ch = '0;
  endtask

  task automatic off0();
    ch[0].off_req = 1'b1;
    cyc(1);
    ch = '0;
    chk("off", 8'h00, {4'h0, on});
  endtask

  initial
  begin
    #1000000;
    mismatches++;
    summarize();
  end

  initial
  begin
    void'($urandom(18));
    cyc(4);
    por_in = 1'b0;
    rst_in = 1'b0;
    rd(CMD_EVENTS_VIEW);
    chk("por byte", EV_POR_VALUE, d);
    chk("summary", 8'h01, {7'h00, summ});
    rd(CMD_EVENTS_CLEAR);
    chk("clear data", EV_POR_VALUE, d);
    rd(CMD_EVENTS_VIEW);
    chk("cleared", 8'h00, d);
    model = 8'h00;
    for (i = 0; i < 16; i++)
    begin
      b = (i < 8) ? (8'h01 << i) : 8'($urandom);
      pulse(b);
      model = model | b;
      rd(i[0] ? CMD_EVENTS_CLEAR : CMD_EVENTS_VIEW);
      chk("event byte", model, d);
      if (i[0])
        model = 8'h00;
    end
    u_pse_host_model.access(8'h0C, d, ok);
    chk("refused", 8'h00, {7'h00, ok});
    ce = 1'b0;
    u_pse_host_model.access(CMD_EVENTS_VIEW, d, ok);
    ce = 1'b1;
    chk("ce refused", 8'h00, {7'h00, ok});
    fork
      u_pse_host_model.access(CMD_EVENTS_CLEAR, d, ok);
      begin
        cyc(1);
        pulse(8'h02);
      end
    join
    chk("clear race", model, d);
    rd(CMD_EVENTS_VIEW);
    chk("kept event", 8'h02, d);
    pulse(8'hFF);
    rst_in = 1'b1;
    cyc(1);
    rst_in = 1'b0;
    rd(CMD_EVENTS_CLEAR);
    chk("pin reset", EV_PRESERVE_MASK, d);
    start(0, 4'h3, 1'b0, 2'b01);
    chk("single inrush", 8'h01, {4'h0, inr});
    fin(0, 2'b01, 2'b00);
    chk("single on", 8'h03, {4'h0, on});
    chk("single pg", 8'h03, {4'h0, pg});
    off0();
    start(0, 4'h6, 1'b0, 2'b01);
    fin(0, 2'b01, 2'b01);
    chk("single cool", 8'h03, {4'h0, cool});
    chk("single flt", 8'h03, {4'h0, sf | on});
    cyc(COOL_N + 2);
    chk("cool end", 8'h00, {4'h0, cool});
    start(0, 4'h7, 1'b0, 2'b01);
    chk("par inrush", 8'h03, {4'h0, inr});
    fin(0, 2'b11, 2'b00);
    chk("par pg", 8'h03, {4'h0, pg & on});
    off0();
    start(0, 4'h8, 1'b0, 2'b01);
    fin(0, 2'b11, 2'b10);
    chk("par cool", 8'h03, {4'h0, cool});
    chk("par flt", 8'h03, {4'h0, sf | on});
    cyc(COOL_N + 2);
    start(1, 4'h3, 1'b1, 2'b11);
    chk("dual inrush", 8'h0C, {4'h0, inr});
    fin(1, 2'b11, 2'b01);
    chk("dual on", 8'h08, {4'h0, on});
    chk("dual cool", 8'h04, {4'h0, cool});
    temp_low = 1'b0;
    pulse(8'h80);
    chk("thermal off", 8'h00, {4'h0, on});
    start(0, 4'h3, 1'b0, 2'b01);
    chk("hold", 8'h00, {4'h0, inr});
    temp_low = 1'b1;
    cyc(1);
    start(0, 4'h3, 1'b0, 2'b01);
    chk("restart", 8'h01, {4'h0, inr});
    rd(CMD_EVENTS_VIEW);
    chk("thermal bit", 8'h80, d & 8'h80);
    summarize();
  end
endmodule
`default_nettype wire
